// file: src/scs_sum_chain.sv
// Transmit carrier sum chain with AXI4-Lite registers and a capture test bus.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`include "scs_cfg.svh"
// What this block does
// - Software selects carriers for four output buses.
// - Each carrier added via mixer bus and offset.
// - Twelve mixer buses, four converters, three each.
// - Mixer bus period is 2, 4 or 8 cycles.
// - Accumulator wider than 18-bit samples.
// - Sum shifted, rounded, saturated to 18 bits.
// - Output interleaves one or two streams.
// - Shift scales in 6 dB steps.
// - Selection and shift change only on sync.
// - Sync source is downlink sync or host.
// - Registers reached over a synchronous bus.
// - Internal samples offered on a test bus.
// - Output buses carry one or two streams.
module scs_sum_chain (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [`SCS_NUM_IN-1:0][`SCS_SAMPLE_W-1:0] conv_mixer_bus,
   input wire logic mix_frame,
   input wire logic downlink_sync,
   output logic [`SCS_NUM_OUT-1:0][`SCS_SAMPLE_W-1:0] reducer_out_bus,
   output logic [`SCS_NUM_OUT-1:0] reducer_out_first,
   output logic reducer_out_q,
   output logic [`SCS_CAP_W-1:0] test_data,
   output logic test_valid,
   input wire logic test_ready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic rst_meta_n;
   logic rst_n;
   scs_pkg::scs_state_t s;
   scs_pkg::scs_state_t next_s;
   scs_fifo_if #(.W(`SCS_CAP_W)) cap_if ();

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   scs_fifo #(.W(`SCS_CAP_W), .D(`SCS_FIFO_D)) u_cap_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .f(cap_if.fifo)
   );

   assign cap_if.wr_valid = s.cap_valid;
   assign cap_if.wr_data = s.cap_data;
   assign cap_if.rd_ready = test_ready;
   assign test_data = cap_if.rd_data;
   assign test_valid = cap_if.rd_valid;

   assign reducer_out_bus = s.out_data;
   assign reducer_out_first = s.out_first;
   assign reducer_out_q = s.out_q;
   assign s_axi_awready = s.aw_rdy;
   assign s_axi_wready = s.w_rdy;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.ar_rdy;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;

   // Byte-lane merge of a write into a stored word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++) begin
         if (strb[k]) begin
            r[8*k +: 8] = nw[8*k +: 8];
         end
      end
      return r;
   endfunction

   // Scales by a signed count of 6 dB steps, rounds half up on attenuation, then clamps.
   function automatic scs_pkg::scs_sample_t scale(input logic signed [`SCS_ACC_W-1:0] acc,
                                                  input logic signed [3:0] sh);
      logic signed [31:0] v;
      logic [3:0] k;
      v = 32'(acc);
      k = 4'(-sh);
      if (!sh[3]) begin
         v = v <<< sh[2:0];
      end else begin
         v = (v + (32'sd1 <<< (k - 4'h1))) >>> k;
      end
      if (v > `SCS_SAT_MAX) begin
         return 18'h1ffff;
      end else if (v < `SCS_SAT_MIN) begin
         return 18'h20000;
      end
      return v[`SCS_SAMPLE_W-1:0];
   endfunction

   always_comb begin
      logic [2:0] ph;
      logic stream;
      logic [3:0] idx;
      logic signed [`SCS_ACC_W-1:0] acc;
      logic [3:0] fld;
      logic apply;
      logic host_sync;
      logic shadow_wr;
      logic [`SCS_ADDR_W-1:0] wa;
      logic [`SCS_ADDR_W-1:0] ra;
      logic [31:0] rv;
      logic [31:0] wv;
      logic hit;
      ph = '0;
      stream = 1'b0;
      idx = '0;
      acc = '0;
      fld = '0;
      apply = 1'b0;
      host_sync = 1'b0;
      shadow_wr = 1'b0;
      wa = '0;
      ra = '0;
      rv = '0;
      wv = '0;
      hit = 1'b0;
      next_s = s;

      // Interleave phase; the frame marker forces cycle zero of the longest period.
      ph = mix_frame ? 3'h0 : s.phase;
      next_s.phase = ph + 3'h1;
      for (int i = 0; i < `SCS_NUM_IN; i++) begin
         next_s.hist[i] = {s.hist[i][`SCS_HIST_D-2:0], conv_mixer_bus[i]};
      end

      for (int b = 0; b < `SCS_NUM_OUT; b++) begin
         stream = s.fmt_act[b] & ph[1];
         idx = 4'(b * `SCS_NUM_STREAM) + 4'(stream);
         acc = '0;
         for (int i = 0; i < `SCS_NUM_IN; i++) begin
            fld = s.sel_act[idx[2:0]][i];
            if (fld[3]) begin
               acc = acc + `SCS_ACC_W'(signed'(s.hist[i][fld[2:0]]));
            end
         end
         next_s.out_data[b] = scale(acc, s.shift_act[4*b +: 4]);
         next_s.out_first[b] = (ph[0] == 1'b0) && (!s.fmt_act[b] || ph[1] == 1'b0);
      end
      next_s.out_q = ph[0];

      // Capture of one output bus; a full FIFO holds the capture word and flags the loss.
      if (s.cap_valid && !cap_if.wr_ready) begin
         if (s.test_sel[`SCS_TEST_EN]) begin
            next_s.overflow = 1'b1;
         end
      end else begin
         next_s.cap_valid = s.test_sel[`SCS_TEST_EN];
         next_s.cap_data = {s.out_first[s.test_sel[1:0]], s.out_q, s.out_data[s.test_sel[1:0]]};
      end

      // Write channel: address and data are taken in either order, answered once both are held.
      if (s_axi_awvalid && s.aw_rdy) begin
         next_s.aw_have = 1'b1;
         next_s.aw_addr = s_axi_awaddr[`SCS_ADDR_W-1:0];
      end
      if (s_axi_wvalid && s.w_rdy) begin
         next_s.w_have = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_have && s.w_have && !s.bvalid) begin
         wa = s.aw_addr;
         hit = 1'b1;
         next_s.aw_have = 1'b0;
         next_s.w_have = 1'b0;
         next_s.bvalid = 1'b1;
         if (wa[11:8] == `SCS_SEL_BASE_PAGE && wa[7:2] < 6'(`SCS_SEL_WORDS)) begin
            idx = wa[6:3];
            if (wa[2]) begin
               wv = merge({16'h0000, s.sel_sh[idx[2:0]][11:8]}, s.w_data, s.w_strb);
               next_s.sel_sh[idx[2:0]][11:8] = wv[15:0];
            end else begin
               wv = merge(s.sel_sh[idx[2:0]][7:0], s.w_data, s.w_strb);
               next_s.sel_sh[idx[2:0]][7:0] = wv;
            end
            shadow_wr = 1'b1;
         end else begin
            case (wa)
               `SCS_OFS_CTRL: begin
                  if (s.w_strb[0]) begin
                     next_s.sync_sel = s.w_data[`SCS_CTRL_SYNC_SEL];
                     host_sync = s.w_data[`SCS_CTRL_HOST_SYNC];
                  end
               end
               `SCS_OFS_STATUS: begin
                  if (s.w_strb[0] && s.w_data[`SCS_STAT_OVERFLOW]) begin
                     next_s.overflow = 1'b0;
                  end
               end
               `SCS_OFS_FORMAT: begin
                  if (s.w_strb[0]) begin
                     next_s.fmt_sh = s.w_data[3:0];
                     shadow_wr = 1'b1;
                  end
               end
               `SCS_OFS_SHIFT: begin
                  wv = merge({16'h0000, s.shift_sh}, s.w_data, s.w_strb);
                  next_s.shift_sh = wv[15:0];
                  shadow_wr = 1'b1;
               end
               `SCS_OFS_TEST: begin
                  if (s.w_strb[0]) begin
                     next_s.test_sel = s.w_data[2:0];
                  end
               end
               default: begin
                  hit = 1'b0;
               end
            endcase
         end
         next_s.bresp = hit ? `SCS_RESP_OKAY : `SCS_RESP_DECERR;
      end

      // Overflow set wins over a clear in the same cycle.
      if (s.cap_valid && !cap_if.wr_ready && s.test_sel[`SCS_TEST_EN]) begin
         next_s.overflow = 1'b1;
      end

      // Shadow settings move to the working copy only on the chosen sync event.
      apply = s.sync_sel ? host_sync : downlink_sync;
      if (apply) begin
         next_s.sel_act = s.sel_sh;
         next_s.fmt_act = s.fmt_sh;
         next_s.shift_act = s.shift_sh;
         next_s.pending = 1'b0;
      end
      if (shadow_wr) begin
         next_s.pending = 1'b1;
      end

      // Read channel.
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.ar_rdy) begin
         ra = s_axi_araddr[`SCS_ADDR_W-1:0];
         hit = 1'b1;
         if (ra[11:8] == `SCS_SEL_BASE_PAGE && ra[7:2] < 6'(`SCS_SEL_WORDS)) begin
            idx = ra[6:3];
            rv = ra[2] ? {16'h0000, s.sel_sh[idx[2:0]][11:8]} : s.sel_sh[idx[2:0]][7:0];
         end else begin
            case (ra)
               `SCS_OFS_CTRL: rv = {31'h00000000, s.sync_sel};
               `SCS_OFS_STATUS: rv = {30'h00000000, s.overflow, s.pending};
               `SCS_OFS_FORMAT: rv = {28'h0000000, s.fmt_sh};
               `SCS_OFS_SHIFT: rv = {16'h0000, s.shift_sh};
               `SCS_OFS_TEST: rv = {29'h00000000, s.test_sel};
               default: begin
                  hit = 1'b0;
                  rv = 32'h00000000;
               end
            endcase
         end
         next_s.rvalid = 1'b1;
         next_s.rdata = rv;
         next_s.rresp = hit ? `SCS_RESP_OKAY : `SCS_RESP_DECERR;
      end

      next_s.aw_rdy = !next_s.aw_have && !next_s.bvalid;
      next_s.w_rdy = !next_s.w_have && !next_s.bvalid;
      next_s.ar_rdy = !next_s.rvalid;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// file: src/scs_cfg.svh
// Constants of the carrier sum chain: sizes, register offsets, fields and reset values.
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
`define SCS_NUM_IN 12
`define SCS_NUM_OUT 4
`define SCS_NUM_STREAM 2
`define SCS_NUM_SEL 8
`define SCS_SAMPLE_W 18
`define SCS_ACC_W 24
`define SCS_HIST_D 8
`define SCS_FIFO_D 32
`define SCS_CAP_W 20
`define SCS_ADDR_W 12
`define SCS_SAT_MAX 32'sd131071
`define SCS_SAT_MIN -32'sd131072
`define SCS_OFS_CTRL 12'h000
`define SCS_OFS_STATUS 12'h004
`define SCS_OFS_FORMAT 12'h008
`define SCS_OFS_SHIFT 12'h00c
`define SCS_OFS_TEST 12'h010
`define SCS_SEL_BASE_PAGE 4'h1
`define SCS_SEL_WORDS 16
`define SCS_CTRL_SYNC_SEL 0
`define SCS_CTRL_HOST_SYNC 1
`define SCS_STAT_PENDING 0
`define SCS_STAT_OVERFLOW 1
`define SCS_TEST_EN 2
`define SCS_FORMAT_RST 4'h0
`define SCS_SHIFT_RST 16'h0000
`define SCS_RESP_OKAY 2'b00
`define SCS_RESP_DECERR 2'b11
`endif

// file: src/scs_pkg.sv
// Types shared by the carrier sum chain modules.
`include "scs_cfg.svh"
package scs_pkg;
   typedef logic [`SCS_SAMPLE_W-1:0] scs_sample_t;
   typedef logic [3:0] scs_sel_field_t;
   typedef logic [`SCS_NUM_IN-1:0][3:0] scs_sel_row_t;
   typedef struct packed {
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
      logic aw_have;
      logic [`SCS_ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sync_sel;
      logic pending;
      logic overflow;
      logic [3:0] fmt_sh;
      logic [3:0] fmt_act;
      logic [15:0] shift_sh;
      logic [15:0] shift_act;
      logic [2:0] test_sel;
      logic [`SCS_NUM_SEL-1:0][`SCS_NUM_IN-1:0][3:0] sel_sh;
      logic [`SCS_NUM_SEL-1:0][`SCS_NUM_IN-1:0][3:0] sel_act;
      logic [`SCS_NUM_IN-1:0][`SCS_HIST_D-1:0][`SCS_SAMPLE_W-1:0] hist;
      logic [2:0] phase;
      logic [`SCS_NUM_OUT-1:0][`SCS_SAMPLE_W-1:0] out_data;
      logic [`SCS_NUM_OUT-1:0] out_first;
      logic out_q;
      logic cap_valid;
      logic [`SCS_CAP_W-1:0] cap_data;
   } scs_state_t;
endpackage

// file: src/scs_fifo_if.sv
// Handshake bundle between the sum chain and its capture FIFO.
interface scs_fifo_if #(parameter int W = 20);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;
   modport user (output wr_valid, output wr_data, output rd_ready, input wr_ready, input rd_valid, input rd_data);
   modport fifo (input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
endinterface

// file: src/scs_fifo.sv
// Capture FIFO with a registered output word.
module scs_fifo #(
   parameter int W = 20,
   parameter int D = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   scs_fifo_if.fifo f
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } scs_fifo_state_t;
   scs_fifo_state_t s;
   scs_fifo_state_t next_s;
   logic push;
   logic pop;

   assign f.wr_ready = (s.cnt != FULL);
   assign f.rd_valid = s.ov;
   assign f.rd_data = s.od;

   always_comb begin
      next_s = s;
      push = f.wr_valid && (s.cnt != FULL);
      pop = (s.cnt != '0) && (!s.ov || f.rd_ready);
      if (push) begin
         next_s.mem[s.wp] = f.wr_data;
         next_s.wp = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.od = s.mem[s.rp];
         next_s.ov = 1'b1;
         next_s.rp = s.rp + 1'b1;
      end else if (f.rd_ready) begin
         next_s.ov = 1'b0;
      end
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// file: dv/scs_sum_chain_chk.sv
// Protocol and stream timing assertions watching the sum chain top module.
`include "scs_cfg.svh"
module scs_sum_chain_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [`SCS_NUM_OUT-1:0] reducer_out_first,
   input wire logic reducer_out_q,
   input wire logic [`SCS_CAP_W-1:0] test_data,
   input wire logic test_valid,
   input wire logic test_ready,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_wr_lat;
      s_wr_take |=> s_wr_answer;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write response not two cycles after handshake");
   property p_wr_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write response dropped before bready");
   property p_wr_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("write ready while response pending");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read data not one cycle after address");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed before rready");
   property p_rd_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_rd_block: assert property (p_rd_block) else $error("read address ready while data pending");
   property p_q_alt;
      reducer_out_q |=> !reducer_out_q ##1 reducer_out_q;
   endproperty
   a_q_alt: assert property (p_q_alt) else $error("I and Q cycles do not alternate");
   property p_first_i;
      reducer_out_first[0] |-> !reducer_out_q ##1 (!reducer_out_first[0] && reducer_out_q);
   endproperty
   a_first_i: assert property (p_first_i) else $error("stream start not on an I cycle");
   property p_cap_hold;
      test_valid && !test_ready |=> test_valid && $stable(test_data);
   endproperty
   a_cap_hold: assert property (p_cap_hold) else $error("test word changed while stalled");
endmodule
bind scs_sum_chain scs_sum_chain_chk chk (.clk, .arst_n, .reducer_out_first, .reducer_out_q, .test_data,
   .test_valid, .test_ready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);

// file: dv/scs_far_model.sv
// Far-side model: converter mixer bus source and a capture sink that stalls.
`include "scs_cfg.svh"
module scs_far_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [`SCS_NUM_IN-1:0][`SCS_SAMPLE_W-1:0] lvl,
   input wire logic stall,
   output logic [`SCS_NUM_IN-1:0][`SCS_SAMPLE_W-1:0] conv_mixer_bus,
   output logic mix_frame,
   output logic test_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ph;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph <= 3'h0;
      end else begin
         ph <= ph + 3'h1;
      end
   end
   // One eight-cycle interleave period, matched to the output bus rate.
   assign mix_frame = (ph == 3'h0);
   assign conv_mixer_bus = lvl;
   // The sink accepts only on alternate cycle pairs, and never while stalled.
   assign test_ready = !stall && ph[1];
endmodule

// file: dv/carrier_sum_chain_bench.sv
// Self-checking bench for the sum chain.
`include "scs_cfg.svh"
module carrier_sum_chain_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int a; int b; int sh;} scs_row_t;
   logic clk = 0, arst_n = 0, downlink_sync = 0, stall = 0;
   logic [`SCS_NUM_IN-1:0][`SCS_SAMPLE_W-1:0] lvl = '0, cmb;
   logic mix_frame, test_ready, reducer_out_q, test_valid;
   logic [`SCS_NUM_OUT-1:0][`SCS_SAMPLE_W-1:0] reducer_out_bus;
   logic [`SCS_NUM_OUT-1:0] reducer_out_first;
   logic [`SCS_CAP_W-1:0] test_data;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
   logic [3:0] wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   int err_count = 0, n_compared = 0, cnt;
   // Two carriers at shift 0; saturation both ways; rounding both signs; gain.
   scs_row_t rows[6] = '{'{1000, 2000, 0}, '{100000, 100000, 0}, '{-100000, -100000, 0},
                         '{3, 0, -1}, '{1000, 1000, 1}, '{-3, 0, -1}};
   always #20 clk = ~clk;
   scs_sum_chain dut (.clk, .arst_n, .conv_mixer_bus(cmb), .mix_frame, .downlink_sync, .reducer_out_bus,
      .reducer_out_first, .reducer_out_q, .test_data, .test_valid, .test_ready, .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   scs_far_model far (.clk, .arst_n, .lvl, .stall, .conv_mixer_bus(cmb), .mix_frame, .test_ready);
   function automatic logic [17:0] exp_out(input int s, input int sh);
      int v;
      v = (sh >= 0) ? (s <<< sh) : ((s + (1 <<< (-sh - 1))) >>> (-sh));
      if (v > 131071) v = 131071;
      if (v < -131072) v = -131072;
      return v[17:0];
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      bit aw, w;
      @(posedge clk);
      aw = 0;
      w = 0;
      awaddr <= {20'h0, a};
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 0; end
         if (!w && wready === 1'b1) begin w = 1; wvalid <= 0; end
      end while (!(aw && w));
      do @(posedge clk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 0;
   endtask
   task automatic axr(input logic [11:0] a);
      @(posedge clk);
      araddr <= {20'h0, a};
      arvalid <= 1;
      rready <= 1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 0;
   endtask
   task automatic pulse_sync();
      @(posedge clk);
      downlink_sync <= 1;
      @(posedge clk);
      downlink_sync <= 0;
   endtask
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      err_count++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1;
      repeat (4) @(posedge clk);
      axr(`SCS_OFS_FORMAT);
      chk("format reset", 32'h0, rd);
      axr(`SCS_OFS_SHIFT);
      chk("shift reset", 32'h0, rd);
      axr(12'h040);
      chk("unmapped rresp", {30'h0, `SCS_RESP_DECERR}, {30'h0, rs});
      axw(12'h040, 32'h1);
      chk("unmapped bresp", {30'h0, `SCS_RESP_DECERR}, {30'h0, rs});
      // Inputs 0 and 1 onto bus 0 stream 0; converters two and three stay unselected.
      axw(12'h100, 32'h0000_0088);
      axw(`SCS_OFS_CTRL, 32'h1);
      foreach (rows[i]) begin
         lvl[0] <= 18'(rows[i].a);
         lvl[1] <= 18'(rows[i].b);
         axw(`SCS_OFS_SHIFT, {28'h0, 4'(rows[i].sh)});
         axw(`SCS_OFS_CTRL, 32'h3);
         repeat (12) @(negedge clk);
         chk("bus0 sum", {14'h0, exp_out(rows[i].a + rows[i].b, rows[i].sh)}, {14'h0, reducer_out_bus[0]});
         chk("bus1 empty", 32'h0, {14'h0, reducer_out_bus[1]});
         chk("bus3 empty", 32'h0, {14'h0, reducer_out_bus[3]});
      end
      axw(`SCS_OFS_CTRL, 32'h0);
      axw(`SCS_OFS_SHIFT, 32'h1);
      axw(`SCS_OFS_CTRL, 32'h2);
      repeat (12) @(negedge clk);
      chk("held shift", {14'h0, exp_out(-3, -1)}, {14'h0, reducer_out_bus[0]});
      axr(`SCS_OFS_STATUS);
      chk("pending set", 32'h1, rd & 32'h1);
      pulse_sync();
      repeat (12) @(negedge clk);
      chk("synced shift", {14'h0, exp_out(-3, 1)}, {14'h0, reducer_out_bus[0]});
      axr(`SCS_OFS_STATUS);
      chk("pending clear", 32'h0, rd & 32'h1);
      axw(12'h108, 32'h0000_0800);
      lvl[2] <= 18'd700;
      axw(`SCS_OFS_FORMAT, 32'h1);
      pulse_sync();
      repeat (12) @(negedge clk);
      cnt = 0;
      while (reducer_out_first[0] !== 1'b1 && cnt < 20) begin @(negedge clk); cnt++; end
      chk("stream0", {14'h0, exp_out(-3, 1)}, {14'h0, reducer_out_bus[0]});
      repeat (2) @(negedge clk);
      chk("stream1", {14'h0, exp_out(700, 1)}, {14'h0, reducer_out_bus[0]});
      chk("first off", 32'h0, {31'h0, reducer_out_first[0]});
      repeat (2) @(negedge clk);
      chk("first period", 32'h1, {31'h0, reducer_out_first[0]});
      axw(`SCS_OFS_TEST, 32'h4);
      stall <= 1;
      repeat (60) @(posedge clk);
      axr(`SCS_OFS_STATUS);
      chk("overflow", 32'h2, rd & 32'h2);
      axw(`SCS_OFS_TEST, 32'h0);
      @(posedge clk);
      stall <= 0;
      cnt = 0;
      repeat (150) begin
         @(negedge clk);
         if (test_valid === 1'b1 && test_ready === 1'b1) begin
            cnt++;
            if (test_data[19]) chk("captured stream0", {14'h0, exp_out(-3, 1)}, {14'h0, test_data[17:0]});
         end
      end
      // Every FIFO entry, the FIFO output word and the held capture word drain.
      chk("drained words ok", 32'h1, {31'h0, cnt == `SCS_FIFO_D + 2});
      chk("empty", 32'h0, {31'h0, test_valid});
      axw(`SCS_OFS_STATUS, 32'h2);
      axr(`SCS_OFS_STATUS);
      chk("overflow clear", 32'h0, rd & 32'h2);
      // Input 3 onto bus 1 stream 0, whose shift field stays at zero.
      axw(12'h110, 32'h0000_8000);
      lvl[3] <= 18'd500;
      pulse_sync();
      repeat (12) @(negedge clk);
      chk("bus1 routed", {14'h0, exp_out(500, 0)}, {14'h0, reducer_out_bus[1]});
      finish_test();
   end
endmodule
